// file: core/pit_top.sv
// Purpose: periodic interrupt timer with an ahb-lite register slave
// Assumes: timer clocks, oscillator status and stop request arrive as pins from other domains
// Notes: reads take one wait state, writes none; response is always okay
// Operation
// - timer counts edges of internal rc clock or oscillator clock, per source select
// - in stop, counting continues only with pseudo stop, stop-run enable and oscillator source
// - control register is readable and writable at any time
// - any control register write restarts the time-out period
// - any change of the source select bit restarts the time-out period
// - control bit 7 picks binary or decimal prescaler family
// - binary rate codes 001 to 111 give bases two to the 10 to 16
// - modulus field multiplies the base divider by its value plus one
// - binary rate code 000 disables the timer; all-zero control after reset
// - interrupt raised while the timer flag is set and its enable is 1
// - source select takes 1 only with oscillator up; loss forces it to 0
// - timer freezes in stop without stop-run enable or with rc clock, count held
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_top #(
  parameter int CW = 18,
  parameter int MW = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // timer clocks and system status pins
  input wire logic INTERNAL_RC_CLOCK,
  input wire logic OSCILLATOR_CLOCK,
  input wire logic OSCILLATOR_UP_STATUS,
  input wire logic STOP_MODE,
  // interrupt and time-out
  output logic PERIODIC_IRQ,
  output logic TIMEOUT_PULSE
);

  // pin synchronisers, stage one feeds stage two only
  logic [3:0] sync_one;
  logic [3:0] sync_two;
  logic irc_prev;
  logic osc_prev;
  logic irc_rise;
  logic osc_rise;
  logic osc_up;
  logic stop_req;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_one <= 4'h0;
      sync_two <= 4'h0;
      irc_prev <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      sync_one <= {STOP_MODE, OSCILLATOR_UP_STATUS, OSCILLATOR_CLOCK, INTERNAL_RC_CLOCK};
      sync_two <= sync_one;
      irc_prev <= sync_two[0];
      osc_prev <= sync_two[1];
    end
  end

  assign irc_rise = sync_two[0] && !irc_prev;
  assign osc_rise = sync_two[1] && !osc_prev;
  assign osc_up = sync_two[2];
  assign stop_req = sync_two[3];

  // ahb address and data phase tracking
  pit_pkg::pit_bus_state_type bus_state;
  pit_pkg::pit_bus_state_type next_bus_state;
  pit_pkg::pit_addr_type bus_addr;
  pit_pkg::pit_addr_type next_bus_addr;
  logic [31:0] next_hrdata;
  logic [31:0] read_value;
  logic accept;
  logic wr_strobe;
  logic wr_hit;

  assign accept = HSEL && HTRANS[1] && HREADY;
  assign wr_strobe = (bus_state == pit_pkg::BUS_WRITE);
  assign wr_hit = wr_strobe && bus_addr.aligned && bus_addr.word;
  assign HREADYOUT = (bus_state != pit_pkg::BUS_READ_WAIT);
  assign HRESP = 1'b0;

  always_comb begin
    next_bus_state = bus_state;
    next_bus_addr = bus_addr;
    next_hrdata = HRDATA;
    unique case (bus_state)
      pit_pkg::BUS_READ_WAIT: begin
        next_hrdata = read_value;
        next_bus_state = pit_pkg::BUS_READ_DONE;
      end
      pit_pkg::BUS_IDLE, pit_pkg::BUS_WRITE, pit_pkg::BUS_READ_DONE: begin
        if (accept) begin
          next_bus_addr.index = HADDR[9:2];
          next_bus_addr.aligned = (HADDR[1:0] == 2'h0) && (HADDR[31:10] == 22'h0);
          next_bus_addr.word = (HSIZE == `PIT_HSIZE_WORD);
          next_bus_state = HWRITE ? pit_pkg::BUS_WRITE : pit_pkg::BUS_READ_WAIT;
        end else begin
          next_bus_state = pit_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_state <= pit_pkg::BUS_IDLE;
      bus_addr <= '0;
      HRDATA <= 32'h0;
    end else begin
      bus_state <= next_bus_state;
      bus_addr <= next_bus_addr;
      HRDATA <= next_hrdata;
    end
  end

  // registers
  pit_pkg::pit_ctrl_type ctrl;
  pit_pkg::pit_ctrl_type next_ctrl;
  logic [7:0] clock_select;
  logic [7:0] next_clock_select;
  logic [7:0] irq_status;
  logic [7:0] next_irq_status;
  logic [7:0] irq_enable;
  logic [7:0] next_irq_enable;
  logic [7:0] irq_events;
  logic ctrl_write;
  logic source_change;
  logic osc_loss;
  logic timeout;

  assign ctrl_write = wr_hit && (bus_addr.index == `PIT_IDX_CONTROL);

  always_comb begin
    next_ctrl = ctrl;
    next_clock_select = clock_select;
    next_irq_enable = irq_enable;
    if (ctrl_write) begin
      next_ctrl = pit_pkg::pit_ctrl_type'(HWDATA[7:0]);
    end
    if (wr_hit && (bus_addr.index == `PIT_IDX_IRQ_ENABLE)) begin
      next_irq_enable = HWDATA[7:0];
    end
    if (wr_hit && (bus_addr.index == `PIT_IDX_CLOCK_SELECT)) begin
      next_clock_select[`PIT_CLKSEL_PSEUDO_STOP_BIT] = HWDATA[`PIT_CLKSEL_PSEUDO_STOP_BIT];
      next_clock_select[`PIT_CLKSEL_STOP_RUN_BIT] = HWDATA[`PIT_CLKSEL_STOP_RUN_BIT];
      // a one is taken only while the oscillator is up
      next_clock_select[`PIT_CLKSEL_SOURCE_BIT] = HWDATA[`PIT_CLKSEL_SOURCE_BIT] && osc_up;
    end
    if (!osc_up) begin
      next_clock_select[`PIT_CLKSEL_SOURCE_BIT] = 1'b0;
    end
  end

  assign source_change = (next_clock_select[`PIT_CLKSEL_SOURCE_BIT] != clock_select[`PIT_CLKSEL_SOURCE_BIT]);
  assign osc_loss = !osc_up && clock_select[`PIT_CLKSEL_SOURCE_BIT];

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= pit_pkg::pit_ctrl_type'(`PIT_CONTROL_RESET);
      clock_select <= `PIT_CLOCK_SELECT_RESET;
      irq_enable <= `PIT_IRQ_ENABLE_RESET;
    end else begin
      ctrl <= next_ctrl;
      clock_select <= next_clock_select;
      irq_enable <= next_irq_enable;
    end
  end

  // sticky event flags; a new event wins over a clear in the same cycle
  always_comb begin
    irq_events = 8'h0;
    irq_events[`PIT_IRQ_TIMEOUT_BIT] = timeout;
    irq_events[`PIT_IRQ_OSC_LOSS_BIT] = osc_loss;
    next_irq_status = irq_status;
    if (wr_hit && (bus_addr.index == `PIT_IDX_IRQ_CLEAR)) begin
      next_irq_status = irq_status & ~HWDATA[7:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status <= 8'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign PERIODIC_IRQ = |(irq_status & irq_enable);

  // divider selection
  logic [CW-1:0] base_m1;
  logic timer_enabled;
  logic selected_tick;
  logic stop_run_allowed;
  logic run;
  logic restart;
  logic [CW-1:0] pre_count;
  logic [MW-1:0] mod_count;

  always_comb begin
    base_m1 = '0;
    if (ctrl.decimal_divider_select) begin
      unique case (ctrl.rate_select)
        3'h0: base_m1 = CW'(`PIT_DEC_BASE_0 - 18'h00001);
        3'h1: base_m1 = CW'(`PIT_DEC_BASE_1 - 18'h00001);
        3'h2: base_m1 = CW'(`PIT_DEC_BASE_2 - 18'h00001);
        3'h3: base_m1 = CW'(`PIT_DEC_BASE_3 - 18'h00001);
        3'h4: base_m1 = CW'(`PIT_DEC_BASE_4 - 18'h00001);
        3'h5: base_m1 = CW'(`PIT_DEC_BASE_5 - 18'h00001);
        3'h6: base_m1 = CW'(`PIT_DEC_BASE_6 - 18'h00001);
        3'h7: base_m1 = CW'(`PIT_DEC_BASE_7 - 18'h00001);
      endcase
    end else begin
      // two to the power of nine plus the rate code, less one
      base_m1 = CW'((32'h1 << (`PIT_BIN_EXP_OFFSET + {2'h0, ctrl.rate_select})) - 32'h1);
    end
  end

  assign timer_enabled = ctrl.decimal_divider_select || (ctrl.rate_select != 3'h0);
  assign selected_tick = clock_select[`PIT_CLKSEL_SOURCE_BIT] ? osc_rise : irc_rise;

  // when stop halts the timer the counter holds; it is not cleared
  assign stop_run_allowed = clock_select[`PIT_CLKSEL_PSEUDO_STOP_BIT]
                            && clock_select[`PIT_CLKSEL_SOURCE_BIT]
                            && clock_select[`PIT_CLKSEL_STOP_RUN_BIT];
  assign run = timer_enabled && (!stop_req || stop_run_allowed);
  assign restart = ctrl_write || source_change;

  pit_divider #(
    .CW(CW),
    .MW(MW)
  ) u_divider (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(selected_tick),
    .restart(restart),
    .run(run),
    .base_m1(base_m1),
    .modulus(ctrl.modulus_select),
    .timeout(timeout),
    .pre_count(pre_count),
    .mod_count(mod_count)
  );

  assign TIMEOUT_PULSE = timeout;

  // register read mux
  always_comb begin
    read_value = 32'h0;
    if (bus_addr.aligned) begin
      unique case (bus_addr.index)
        `PIT_IDX_CONTROL: read_value = {24'h0, ctrl};
        `PIT_IDX_CLOCK_SELECT: read_value = {24'h0, clock_select};
        `PIT_IDX_IRQ_STATUS: read_value = {24'h0, irq_status};
        `PIT_IDX_IRQ_ENABLE: read_value = {24'h0, irq_enable};
        `PIT_IDX_COUNT: read_value = 32'({mod_count, pre_count});
        default: read_value = 32'h0;
      endcase
    end
  end

endmodule // pit_top

`default_nettype wire

// file: core/pit_params.svh
// Purpose: constants of the periodic interrupt timer: register indexes, field positions, resets, divider bases
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// register indexes, byte address is index times four
`define PIT_IDX_CLOCK_SELECT 8'h39
`define PIT_IDX_CONTROL 8'h3b
`define PIT_IDX_IRQ_STATUS 8'h3c
`define PIT_IDX_IRQ_CLEAR 8'h3d
`define PIT_IDX_IRQ_ENABLE 8'h3e
`define PIT_IDX_COUNT 8'h3f

// clock select fields
`define PIT_CLKSEL_PSEUDO_STOP_BIT 6
`define PIT_CLKSEL_STOP_RUN_BIT 3
`define PIT_CLKSEL_SOURCE_BIT 1

// interrupt status, clear and enable fields
`define PIT_IRQ_TIMEOUT_BIT 7
`define PIT_IRQ_OSC_LOSS_BIT 1

// reset values
`define PIT_CONTROL_RESET 8'h00
`define PIT_CLOCK_SELECT_RESET 8'h00
`define PIT_IRQ_ENABLE_RESET 8'h00

// ahb size code of a whole word
`define PIT_HSIZE_WORD 3'h2

// binary base divider is two to the power of this plus the rate code
`define PIT_BIN_EXP_OFFSET 5'h09

// decimal base dividers 1000 to 200000
`define PIT_DEC_BASE_0 18'h003e8
`define PIT_DEC_BASE_1 18'h007d0
`define PIT_DEC_BASE_2 18'h01388
`define PIT_DEC_BASE_3 18'h02710
`define PIT_DEC_BASE_4 18'h04e20
`define PIT_DEC_BASE_5 18'h0c350
`define PIT_DEC_BASE_6 18'h186a0
`define PIT_DEC_BASE_7 18'h30d40

`endif

// file: core/pit_pkg.sv
// Purpose: types of the periodic interrupt timer
// Assumes: nothing beyond the constants header
// Notes: nothing is imported; users write pit_pkg::name
`default_nettype none
package pit_pkg;

  // periodic timer control register layout
  typedef struct packed {
    logic decimal_divider_select;
    logic [2:0] rate_select;
    logic [3:0] modulus_select;
  } pit_ctrl_type;

  // ahb data phase tracking
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } pit_bus_state_type;

  // captured address phase
  typedef struct packed {
    logic [7:0] index;
    logic aligned;
    logic word;
  } pit_addr_type;

endpackage

`default_nettype wire

// file: core/pit_divider.sv
// Purpose: prescaler and modulus counter producing one pulse per time-out period
// Assumes: tick is a one-cycle pulse per edge of the selected timer clock
// Notes: restart wins over counting; count holds while run is low
`timescale 1ns/1ps
`default_nettype none

module pit_divider #(
  parameter int CW = 18,
  parameter int MW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic restart,
  input wire logic run,
  input wire logic [CW-1:0] base_m1,
  input wire logic [MW-1:0] modulus,
  // results
  output logic timeout,
  output logic [CW-1:0] pre_count,
  output logic [MW-1:0] mod_count
);

  logic [CW-1:0] next_pre_count;
  logic [MW-1:0] next_mod_count;
  logic next_timeout;

  always_comb begin
    next_pre_count = pre_count;
    next_mod_count = mod_count;
    next_timeout = 1'b0;
    if (restart) begin
      next_pre_count = '0;
      next_mod_count = '0;
    end else if (run && tick) begin
      if (pre_count >= base_m1) begin
        next_pre_count = '0;
        if (mod_count >= modulus) begin
          next_mod_count = '0;
          next_timeout = 1'b1;
        end else begin
          next_mod_count = mod_count + 1'b1;
        end
      end else begin
        next_pre_count = pre_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_count <= '0;
      mod_count <= '0;
      timeout <= 1'b0;
    end else begin
      pre_count <= next_pre_count;
      mod_count <= next_mod_count;
      timeout <= next_timeout;
    end
  end

endmodule // pit_divider

`default_nettype wire

// file: dv/pit_asserts.sv
// Purpose: port checks of the periodic timer
// Assumes: one ahb master making word transfers
// Notes: shadows the enable and source bits from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // timer
  input wire logic OSCILLATOR_UP_STATUS,
  input wire logic STOP_MODE,
  input wire logic PERIODIC_IRQ,
  input wire logic TIMEOUT_PULSE
);
  logic rd_q;
  logic wr_q;
  logic src;
  logic [7:0] ix;
  logic [7:0] en;
  wire logic tk = HSEL && HTRANS[1] && HREADYOUT;
  wire logic ctl_wr = wr_q && ix == `PIT_IDX_CONTROL;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ix <= 8'h00;
      en <= 8'h00;
      src <= 1'b0;
    end else begin
      rd_q <= tk && !HWRITE;
      wr_q <= tk && HWRITE && HADDR[1:0] == 2'h0 && HSIZE == `PIT_HSIZE_WORD;
      if (tk)
        ix <= HADDR[9:2];
      if (wr_q && ix == `PIT_IDX_IRQ_ENABLE)
        en <= HWDATA[7:0];
      if (!OSCILLATOR_UP_STATUS)
        src <= 1'b0;
      else if (wr_q && ix == `PIT_IDX_CLOCK_SELECT)
        src <= HWDATA[1];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (tk && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  chk_wait_cause: assert property (!HREADYOUT |-> rd_q)
    else $error("wait state without read");
  chk_pulse_gap: assert property (TIMEOUT_PULSE |=> !TIMEOUT_PULSE [*8])
    else $error("time-out pulses too close");
  chk_write_restart: assert property (ctl_wr |-> ##2 !TIMEOUT_PULSE [*8])
    else $error("pulse soon after control write");
  chk_irq_on_pulse: assert property (TIMEOUT_PULSE && en[7] |-> ##[1:2] PERIODIC_IRQ)
    else $error("enabled time-out gave no interrupt");
  chk_irq_masked: assert property (en == 8'h00 |-> !PERIODIC_IRQ)
    else $error("interrupt while all disabled");
  chk_stop_freeze: assert property (STOP_MODE [*5] ##0 !src |-> !TIMEOUT_PULSE)
    else $error("pulse in stop on rc clock");
endmodule // pit_asserts

bind pit_top pit_asserts i_pit_asserts (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
  .HREADYOUT, .HRESP, .OSCILLATOR_UP_STATUS, .STOP_MODE, .PERIODIC_IRQ, .TIMEOUT_PULSE);

`default_nettype wire

// file: dv/pit_tb_top.sv
// Purpose: self-checking bench of the periodic timer
// Assumes: rc clock period 4 cycles, oscillator clock 8 cycles
// Notes: random control values come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_tb_top;
  localparam logic [7:0] XS = `PIT_IDX_CLOCK_SELECT;
  localparam logic [7:0] XC = `PIT_IDX_CONTROL;
  localparam logic [7:0] XT = `PIT_IDX_IRQ_STATUS;
  localparam logic [7:0] XK = `PIT_IDX_IRQ_CLEAR;
  localparam logic [7:0] XE = `PIT_IDX_IRQ_ENABLE;
  localparam int LIMIT = 100000;
  logic clk, rst, hsel, hwrite, hrdy, hresp, up, stp, irq, tp;
  logic rc = 1'b0;
  logic osc = 1'b0;
  logic [2:0] ph = 3'h0;
  logic [1:0] htrans;
  logic [2:0] hsize, sz;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] c;
  int mismatches, num_checks, cyc, np, tlast, t0, t1, n, p;

  pit_top i_pit_top (.CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .INTERNAL_RC_CLOCK(rc), .OSCILLATOR_CLOCK(osc),
    .OSCILLATOR_UP_STATUS(up), .STOP_MODE(stp), .PERIODIC_IRQ(irq), .TIMEOUT_PULSE(tp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // timer clocks, cycle count, pulse log and watchdog
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    rc <= ph[1];
    osc <= ph[2];
    cyc <= cyc + 1;
    if (tp === 1'b1) begin
      np <= np + 1;
      tlast <= cyc;
    end
    if (cyc == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; ready and read data are sampled at the rising edge
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    haddr <= {22'h0, ix, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask

  task automatic rd(input logic [7:0] ix);
    bus(1'b0, ix, 8'h00);
  endtask

  // period in system cycles; decimal form covers rate code 0 only
  function automatic int per(input logic [7:0] cv, input bit os);
    int b;
    b = cv[7] ? 1000 : (1 << (9 + cv[6:4]));
    return b * (cv[3:0] + 1) * (os ? 8 : 4);
  endfunction

  task automatic wait_pulses(input int k);
    n = np + k;
    while (np < n) @(negedge clk);
  endtask

  task automatic period(input logic [7:0] cv, input bit os, input logic [7:0] en);
    wr(XE, en);
    wr(XC, cv);
    wait_pulses(1);
    t0 = tlast;
    wait_pulses(1);
    chk("period", tlast - t0, per(cv, os));
    repeat (2) @(negedge clk);
    chk("irq", irq, en[7]);
    wr(XK, 8'h80);
    @(negedge clk);
    chk("irq cleared", irq, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `PIT_HSIZE_WORD;
    sz = `PIT_HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    up = 1'b0;
    stp = 1'b0;
    void'($urandom(90));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(XC);
    chk("control reset", q, 32'h0);
    chk("response okay", hresp, 32'h0);
    rd(XT);
    chk("status reset", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = 8'($urandom);
      wr(XC, c);
      rd(XC);
      chk("control rw", q, {24'h0, c});
    end
    // a byte-sized write must leave the control register alone
    sz = 3'h0;
    wr(XC, ~c);
    sz = `PIT_HSIZE_WORD;
    rd(XC);
    chk("byte write refused", q, {24'h0, c});
    rd(8'h10);
    chk("unmapped", q, 32'h0);
    rd(XK);
    chk("clear reads", q, 32'h0);
    wr(XS, 8'h02);
    rd(XS);
    chk("source without osc", q[1], 1'b0);
    wr(XC, 8'h0f);
    repeat (4) @(negedge clk);
    t1 = np;
    repeat (5000) @(negedge clk);
    chk("timer off", np - t1, 0);
    c = 8'h10 | 8'($urandom % 2);
    period(c, 1'b0, 8'h80);
    p = per(c, 1'b0);
    repeat (p / 2) @(negedge clk);
    t0 = cyc;
    wr(XC, c);
    wait_pulses(1);
    chk("restart", (tlast - t0 > p - 8) && (tlast - t0 < p + 16), 1'b1);
    period(8'h80, 1'b0, 8'h00);
    @(posedge clk) up <= 1'b1;
    repeat (4) @(negedge clk);
    wr(XS, 8'h02);
    rd(XS);
    chk("source osc", q[1], 1'b1);
    period(8'h10, 1'b1, 8'h80);
    // pseudo stop with run enable on the oscillator keeps counting
    wr(XS, 8'h4a);
    wr(XC, 8'h10);
    @(posedge clk) stp <= 1'b1;
    t1 = np;
    repeat (9000) @(negedge clk);
    chk("pseudo stop runs", np - t1, 1);
    @(posedge clk) up <= 1'b0;
    repeat (8) @(negedge clk);
    t1 = np;
    repeat (9000) @(negedge clk);
    chk("stop on rc halts", np - t1, 0);
    rd(XS);
    chk("source forced", q[1], 1'b0);
    rd(XT);
    chk("loss and time-out flags", q, 32'h82);
    @(posedge clk) stp <= 1'b0;
    // software turns the timer off with the all-zero setting
    wr(XC, 8'h00);
    t1 = np;
    repeat (5000) @(negedge clk);
    chk("zero setting off", np - t1, 0);
    print_verdict();
  end
endmodule // pit_tb_top

`default_nettype wire
